// file: shared/eqr_pkg.sv
package eqr_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] P1_RATE_LOW_OFS  = 8'h18;
  localparam logic [7:0] P1_RATE_HIGH_OFS = 8'h19;
  localparam logic [7:0] P2_RATE_LOW_OFS  = 8'h28;
  localparam logic [7:0] P2_RATE_HIGH_OFS = 8'h29;
  localparam logic [7:0] P3_RATE_LOW_OFS  = 8'h38;
  localparam logic [7:0] P3_RATE_HIGH_OFS = 8'h39;
  localparam logic [7:0] SHAPER_CTRL_OFS  = 8'h10;
  localparam logic [7:0] SHAPER_STAT_OFS  = 8'h11;

  localparam logic [7:0] RATE_RESET       = 8'h00;
  localparam logic [7:0] CTRL_RESET       = 8'h01;
  localparam logic [7:0] RDATA_UNMAPPED   = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int LO_NIB_LSB       = 0;
  localparam int HI_NIB_LSB       = 4;
  localparam int CTRL_MULTIQ_BIT  = 0;
  localparam int CTRL_SPEED10_LSB = 1;
  localparam int STAT_SENDING_BIT = 0;
  localparam int STAT_DEFER_BIT   = 1;
  localparam int STAT_PENDING_BIT = 2;

  // ****************************************************************
  // Sizes and codes
  // ****************************************************************
  localparam int NUM_PORTS   = 3;
  localparam int NUM_QUEUES  = 4;
  localparam int NUM_BUCKETS = NUM_PORTS * NUM_QUEUES;
  localparam int DATA_W      = 8;
  localparam int WORD_W      = DATA_W + 5;
  localparam int FIFO_DEPTH  = 8;
  localparam int CREDIT_W    = 26;

  localparam logic [3:0] CODE_UNLIMITED = 4'h0;
  localparam logic [3:0] CODE_10M_MAX   = 4'h8;

  // ****************************************************************
  // Timing: credit is kept in millibits, refilled once a microsecond,
  // so a rate in Kbps is exactly the refill step in millibits.
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  localparam logic signed [CREDIT_W-1:0] BYTE_COST  = 26'sh0001F40;
  localparam logic signed [CREDIT_W-1:0] CREDIT_CAP = 26'sh0B94D80;
  localparam logic signed [CREDIT_W-1:0] CREDIT_MIN = -CREDIT_CAP;

  typedef enum logic [0:0] {
    EQR_IDLE = 1'b0,
    EQR_SEND = 1'b1
  } eqr_state_type;

  function automatic logic [16:0] eqr_rate_kbps(input logic [3:0] code);
    logic [16:0] r;
    r = 17'h00000;
    case (code)
      4'h1:    r = 17'h00040;
      4'h2:    r = 17'h00080;
      4'h3:    r = 17'h00100;
      4'h4:    r = 17'h00200;
      4'h5:    r = 17'h003E8;
      4'h6:    r = 17'h007D0;
      4'h7:    r = 17'h00FA0;
      4'h8:    r = 17'h01F40;
      4'h9:    r = 17'h03E80;
      4'hA:    r = 17'h07D00;
      4'hB:    r = 17'h0BB80;
      4'hC:    r = 17'h0FA00;
      4'hD:    r = 17'h11940;
      4'hE:    r = 17'h13880;
      4'hF:    r = 17'h157C0;
      default: r = 17'h00000;
    endcase
    return r;
  endfunction

endpackage

// file: verilog/eqr_fifo.sv
`timescale 1ns/1ps
module eqr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_SLOT  = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      count    <= '0;
      in_ready <= 1'b1;
    end else begin
      count    <= next_count;
      // Ready is registered so the source sees a clean level
      in_ready <= (next_count != FULL_COUNT);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

// file: verilog/eqr_shaper.sv
// Behaviour
// - First register per port: queue 1 code upper nibble, queue 0 lower nibble.
// - Second register per port: queue 3 code upper nibble, queue 2 lower nibble.
// - Code 0000 means unshaped; every code resets to 0000.
// - Codes 0001-0100 shape to 64, 128, 256, 512 Kbps.
// - Codes 0101-1011 shape to 1, 2, 4, 8, 16, 32, 48 Mbps.
// - Codes 1100-1111 shape to 64, 72, 80, 88 Mbps.
// - On a 10 Mbit port, codes above 10 Mbps act as 0000.
// - With one queue per port, only the queue 0 code shapes traffic.
// - Register pair repeats per port at 0x18/0x19, 0x28/0x29, 0x38/0x39.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module eqr_shaper (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [7:0]  in_data,
  input  wire logic        in_last,
  input  wire logic [1:0]  in_port,
  input  wire logic [1:0]  in_prio,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [7:0]       out_data,
  output logic             out_last,
  output logic [1:0]       out_port,
  output logic [1:0]       out_prio
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0] eg_rate [2*eqr_pkg::NUM_PORTS];
  logic [7:0] shaper_ctrl;
  logic [7:0] shaper_stat;
  logic       multi_q;
  logic [2:0] speed_10m;
  logic       rate_hit;
  logic [2:0] rate_idx;

  assign multi_q   = shaper_ctrl[eqr_pkg::CTRL_MULTIQ_BIT];
  assign speed_10m = shaper_ctrl[eqr_pkg::CTRL_SPEED10_LSB +: 3];

  // Port n occupies 0xn8 and 0xn9 for n = 1..3
  always_comb begin
    rate_hit = 1'b0;
    rate_idx = 3'h0;
    if (reg_addr[3:1] == 3'h4 && reg_addr[7:4] >= 4'h1 && reg_addr[7:4] <= 4'h3) begin
      rate_hit = 1'b1;
      rate_idx = {reg_addr[5:4] - 2'h1, reg_addr[0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 2*eqr_pkg::NUM_PORTS; i++) begin
        eg_rate[i] <= eqr_pkg::RATE_RESET;
      end
    end else if (reg_wr && rate_hit) begin
      eg_rate[rate_idx] <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      shaper_ctrl <= eqr_pkg::CTRL_RESET;
    end else if (reg_wr && reg_addr == eqr_pkg::SHAPER_CTRL_OFS) begin
      shaper_ctrl <= {4'h0, reg_wdata[3:0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= eqr_pkg::RDATA_UNMAPPED;
    end else if (reg_rd) begin
      if (rate_hit) begin
        reg_rdata <= eg_rate[rate_idx];
      end else if (reg_addr == eqr_pkg::SHAPER_CTRL_OFS) begin
        reg_rdata <= shaper_ctrl;
      end else if (reg_addr == eqr_pkg::SHAPER_STAT_OFS) begin
        reg_rdata <= shaper_stat;
      end else begin
        reg_rdata <= eqr_pkg::RDATA_UNMAPPED;
      end
    end else begin
      // Read data stand for one cycle only
      reg_rdata <= eqr_pkg::RDATA_UNMAPPED;
    end
  end

  // ****************************************************************
  // Input buffer
  // ****************************************************************
  logic [eqr_pkg::WORD_W-1:0] head_word;
  logic                       head_valid;
  logic                       pop;

  eqr_fifo #(
    .WIDTH (eqr_pkg::WORD_W),
    .DEPTH (eqr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   ({in_prio, in_port, in_last, in_data}),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head_word)
  );

  logic [7:0] head_data;
  logic       head_last;
  logic [1:0] head_port;
  logic [1:0] head_prio;
  logic [1:0] head_q;
  logic [3:0] head_idx;

  assign head_data = head_word[7:0];
  assign head_last = head_word[8];
  assign head_port = head_word[10:9];
  assign head_prio = head_word[12:11];
  assign head_q    = multi_q ? head_prio : 2'h0;
  assign head_idx  = {head_port, head_q};

  // ****************************************************************
  // Credit meters, one per port and queue
  // ****************************************************************
  logic [5:0]                           tick_cnt;
  logic                                 tick;
  logic [3:0]                           eff_code [eqr_pkg::NUM_BUCKETS];
  logic signed [eqr_pkg::CREDIT_W-1:0]  credit   [eqr_pkg::NUM_BUCKETS];
  logic [3:0]                           cur_idx;

  always_ff @(posedge mclk) begin
    if (reset) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 6'h01;
    end
  end

  assign tick = (tick_cnt == 6'(eqr_pkg::TICK_CYCLES - 1));

  for (genvar g = 0; g < eqr_pkg::NUM_BUCKETS; g++) begin : g_bucket
    localparam int P = g / eqr_pkg::NUM_QUEUES;
    localparam int Q = g % eqr_pkg::NUM_QUEUES;
    localparam int R = 2 * P + Q / 2;
    localparam int L = (Q % 2 == 1) ? eqr_pkg::HI_NIB_LSB : eqr_pkg::LO_NIB_LSB;

    logic [3:0]                          raw_code;
    logic                                debit;
    logic signed [eqr_pkg::CREDIT_W-1:0] step;
    logic signed [eqr_pkg::CREDIT_W-1:0] next_credit;

    assign raw_code = eg_rate[R][L +: 4];

    always_comb begin
      eff_code[g] = raw_code;
      if (!multi_q && Q != 0) begin
        eff_code[g] = eqr_pkg::CODE_UNLIMITED;
      end else if (speed_10m[P] && raw_code > eqr_pkg::CODE_10M_MAX) begin
        eff_code[g] = eqr_pkg::CODE_UNLIMITED;
      end
    end

    assign debit = pop && (cur_idx == 4'(g));
    assign step  = tick ? $signed({9'h000, eqr_pkg::eqr_rate_kbps(eff_code[g])}) : '0;

    // Deficit meter: a frame may start at zero credit and drive it negative,
    // so long frames are never cut, and the deficit pays back before the next.
    always_comb begin
      next_credit = credit[g] + step - (debit ? eqr_pkg::BYTE_COST : '0);
      if (next_credit > eqr_pkg::CREDIT_CAP) begin
        next_credit = eqr_pkg::CREDIT_CAP;
      end else if (next_credit < eqr_pkg::CREDIT_MIN) begin
        next_credit = eqr_pkg::CREDIT_MIN;
      end
    end

    always_ff @(posedge mclk) begin
      if (reset) begin
        credit[g] <= eqr_pkg::CREDIT_CAP;
      end else if (eff_code[g] == eqr_pkg::CODE_UNLIMITED) begin
        credit[g] <= eqr_pkg::CREDIT_CAP;
      end else begin
        credit[g] <= next_credit;
      end
    end
  end

  // ****************************************************************
  // Frame gate
  // ****************************************************************
  eqr_pkg::eqr_state_type state;
  logic                   head_ok;
  logic                   out_free;

  // Port value 3 has no meter and passes unshaped
  assign head_ok  = (head_port == 2'h3) || (credit[head_idx] >= 0);
  assign out_free = !out_valid || out_ready;
  assign pop      = (state == eqr_pkg::EQR_SEND) && head_valid && out_free;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state   <= eqr_pkg::EQR_IDLE;
      cur_idx <= 4'hF;
    end else begin
      case (state)
        eqr_pkg::EQR_IDLE: begin
          if (head_valid && head_ok) begin
            state   <= eqr_pkg::EQR_SEND;
            cur_idx <= head_idx;
          end
        end
        eqr_pkg::EQR_SEND: begin
          if (pop && head_last) begin
            state   <= eqr_pkg::EQR_IDLE;
            cur_idx <= 4'hF;
          end
        end
        default: begin
          state   <= eqr_pkg::EQR_IDLE;
          cur_idx <= 4'hF;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_data  <= 8'h00;
      out_last  <= 1'b0;
      out_port  <= 2'h0;
      out_prio  <= 2'h0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= head_data;
      out_last  <= head_last;
      out_port  <= head_port;
      out_prio  <= head_prio;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      shaper_stat <= 8'h00;
    end else begin
      shaper_stat                            <= 8'h00;
      shaper_stat[eqr_pkg::STAT_SENDING_BIT] <= (state == eqr_pkg::EQR_SEND);
      shaper_stat[eqr_pkg::STAT_DEFER_BIT]   <= (state == eqr_pkg::EQR_IDLE) && head_valid
                                                && !head_ok;
      shaper_stat[eqr_pkg::STAT_PENDING_BIT] <= head_valid;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  logic all_zero;
  always_comb begin
    all_zero = 1'b1;
    for (int i = 0; i < 2*eqr_pkg::NUM_PORTS; i++) begin
      if (eg_rate[i] != 8'h00) begin
        all_zero = 1'b0;
      end
    end
  end

  sequence launch_s;
    state == eqr_pkg::EQR_IDLE && head_valid && head_ok;
  endsequence

  sequence blocked_s;
    state == eqr_pkg::EQR_IDLE && head_valid && !head_ok;
  endsequence

  reset_unlim_a: assert property (@(posedge mclk) $fell(reset) |-> all_zero)
    else $error("rate codes not zero after reset");

  port2_write_a: assert property (
      reg_wr && reg_addr == eqr_pkg::P2_RATE_HIGH_OFS
      |=> eg_rate[3] == $past(reg_wdata))
    else $error("port 2 second rate register not written");

  high_nibble_a: assert property (
      reg_wr && reg_addr == eqr_pkg::P1_RATE_LOW_OFS |=> eff_code[1] == $past(reg_wdata[7:4])
      || !multi_q || speed_10m[0])
    else $error("queue 1 code not in upper nibble");

  queue3_map_a: assert property (
      reg_wr && reg_addr == eqr_pkg::P3_RATE_HIGH_OFS && multi_q && !speed_10m[2]
      |=> eff_code[11] == $past(reg_wdata[7:4]) || !multi_q || speed_10m[2])
    else $error("queue 3 code not in upper nibble");

  ten_meg_clamp_a: assert property (
      speed_10m[1] && eg_rate[2][3:0] > eqr_pkg::CODE_10M_MAX |-> eff_code[4] == 4'h0)
    else $error("fast code not cleared on 10 Mbit port");

  single_queue_a: assert property (
      !multi_q && state == eqr_pkg::EQR_SEND && cur_idx != 4'hF |-> cur_idx[1:0] == 2'h0)
    else $error("frame metered on non-zero queue in single queue mode");

  refill_step_a: assert property (
      tick && eff_code[0] == 4'h1 && !(pop && cur_idx == 4'h0)
      && credit[0] < eqr_pkg::CREDIT_CAP - 26'sh0000040
      |=> credit[0] == $past(credit[0]) + 26'sh0000040)
    else $error("64 Kbps refill step wrong");

  mid_step_a: assert property (
      tick && eff_code[6] == 4'hB && !(pop && cur_idx == 4'h6)
      && credit[6] < eqr_pkg::CREDIT_CAP - 26'sh000BB80
      |=> credit[6] == $past(credit[6]) + 26'sh000BB80)
    else $error("48 Mbps refill step wrong");

  top_step_a: assert property (
      tick && eff_code[1] == 4'hF && !(pop && cur_idx == 4'h1)
      && credit[1] < eqr_pkg::CREDIT_CAP - 26'sh00157C0
      |=> credit[1] == $past(credit[1]) + 26'sh00157C0)
    else $error("88 Mbps refill step wrong");

  defer_hold_a: assert property (
      blocked_s ##1 blocked_s |-> !out_valid || $past(out_valid))
    else $error("deferred frame started");

  launch_send_a: assert property (launch_s |=> state == eqr_pkg::EQR_SEND)
    else $error("eligible frame not launched");

  unlimited_cap_a: assert property (
      eff_code[0] == 4'h0 ##1 eff_code[0] == 4'h0 |-> credit[0] == eqr_pkg::CREDIT_CAP)
    else $error("unlimited meter not held full");

  // A stalled link must never lose or alter the byte on offer
  out_hold_a: assert property (
      out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
    else $error("held output byte changed");

endmodule

// file: test/eqr_link_sink.sv
`timescale 1ns/1ps
// ********
// Link partner: takes bytes, can stall
// ********
module eqr_link_sink (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [1:0] mode,
  output logic            out_ready
);
  integer seed = 32'h1D2;
  // Mode 0 always takes, 1 stalls at random, 2 holds off so the buffer fills
  always @(posedge mclk) begin
    if (reset) begin
      out_ready <= 1'b0;
    end else begin
      case (mode)
        2'h0: out_ready <= 1'b1;
        2'h1: out_ready <= ($random(seed) % 3) != 0;
        default: out_ready <= 1'b0;
      endcase
    end
  end
endmodule

// file: test/egress_queue_rate_limiter_bench.sv
`timescale 1ns/1ps
module egress_queue_rate_limiter_bench;
  logic        mclk;
  logic        reset;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        in_valid;
  logic        in_ready;
  logic [7:0]  in_data;
  logic        in_last;
  logic [1:0]  in_port;
  logic [1:0]  in_prio;
  logic        out_valid;
  logic        out_ready;
  logic [7:0]  out_data;
  logic        out_last;
  logic [1:0]  out_port;
  logic [1:0]  out_prio;
  logic [1:0]  sink_mode;
  integer      seed = 32'he466;
  integer      bad_count = 0;
  integer      check_count = 0;
  longint      cyc = 0;
  longint      t_first = 0;
  longint      t_end = 0;
  longint      last_gap = 0;
  longint      dur_prev = 0;
  logic        prev_last = 1'b1;
  logic        rd_pend = 1'b0;
  logic [12:0] exp_q[$];
  logic [7:0]  rd_q[$];
  logic [7:0]  vals[6];
  logic [7:0]  rate_addr[6] = '{8'h18, 8'h19, 8'h28, 8'h29, 8'h38, 8'h39};

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  eqr_shaper i_dut (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .in_last(in_last),
    .in_port(in_port), .in_prio(in_prio), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_last(out_last), .out_port(out_port), .out_prio(out_prio)
  );

  eqr_link_sink i_sink (
    .mclk(mclk), .reset(reset), .mode(sink_mode), .out_ready(out_ready)
  );

  // ********
  // Shared tasks
  // ********
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_range(input longint got, input longint lo, input longint hi);
    check_count++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("ERROR t=%0t gap=%0h range=%0h..%0h", $time, got, lo, hi);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rd_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask

  task automatic send_frame(input logic [1:0] p, input logic [1:0] q, input int n);
    logic [7:0] d;
    @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      d = $random(seed);
      in_valid <= 1'b1;
      in_data <= d;
      in_last <= (i == n - 1);
      in_port <= p;
      in_prio <= q;
      exp_q.push_back({i == n - 1, p, q, d});
      do @(posedge mclk); while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0;
  endtask

  task automatic drain();
    for (int k = 0; k < 20000 && exp_q.size() != 0; k++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    chk(exp_q.size(), 0);
  endtask

  // Long frame drives a limited meter into deficit; the follow-up frame must wait it out, or follow within 8 cycles when r is 0
  task automatic rate_case(input logic [1:0] p, input logic [1:0] q, input int n,
                           input longint r);
    longint w;
    send_frame(p, q, n);
    send_frame(p, q, 1);
    drain();
    if (r == 0) begin
      chk_range(last_gap, 1, 8);
    end else begin
      w = n * longint'(eqr_pkg::BYTE_COST) - longint'(eqr_pkg::CREDIT_CAP);
      w = (w - dur_prev * r / eqr_pkg::TICK_CYCLES) * eqr_pkg::TICK_CYCLES / r;
      chk_range(last_gap, w * 9 / 10, w * 11 / 10 + 60);
    end
  endtask

  // ********
  // Result watchers
  // ********
  always @(posedge mclk) begin
    cyc++;
    rd_pend <= reg_rd;
    if (rd_pend) begin
      chk(reg_rdata, rd_q.pop_front());
    end else if (!reset) begin
      chk(reg_rdata, 8'h00);
    end
    if (!reset && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (prev_last) begin
        last_gap = cyc - t_end;
        dur_prev = t_end - t_first;
        t_first = cyc;
      end
      if (out_last) t_end = cyc;
      prev_last = out_last;
      chk({out_last, out_port, out_prio, out_data},
          exp_q.size() != 0 ? exp_q.pop_front() : 'x);
    end
  end

  always @(posedge mclk) begin
    if (cyc == 60000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ********
  // Main sequence
  // ********
  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    in_valid = 1'b0;
    in_data = 8'h00;
    in_last = 1'b0;
    in_port = 2'h0;
    in_prio = 2'h0;
    sink_mode = 2'h1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) reg_read(rate_addr[i], 8'h00);
    reg_read(8'h10, 8'h01);
    reg_write(8'h1A, 8'h5A);
    reg_read(8'h1A, 8'h00);
    for (int i = 0; i < 6; i++) begin
      vals[i] = $random(seed);
      reg_write(rate_addr[i], vals[i]);
    end
    for (int i = 0; i < 6; i++) reg_read(rate_addr[i], vals[i]);
    for (int c = 0; c < 16; c++) begin
      reg_write(8'h18, {4'(c), ~4'(c)});
      reg_read(8'h18, {4'(c), ~4'(c)});
      reg_write(8'h29, {~4'(c), 4'(c)});
      reg_read(8'h29, {~4'(c), 4'(c)});
    end
    for (int i = 0; i < 6; i++) reg_write(rate_addr[i], 8'h00);
    // Stalled link: buffer must refuse, then hand over every byte
    sink_mode <= 2'h2;
    fork
      send_frame(2'h0, 2'h0, 16);
    join_none
    repeat (40) @(posedge mclk);
    chk(in_ready, 1'b0);
    sink_mode <= 2'h1;
    wait fork;
    drain();
    sink_mode <= 2'h0;
    // Lowest rate: second frame held back, released once unlimited
    reg_write(8'h18, 8'h01);
    send_frame(2'h0, 2'h0, 1600);
    send_frame(2'h0, 2'h0, 1);
    repeat (3000) @(posedge mclk);
    chk(exp_q.size(), 1);
    // Status: idle, head frame deferred, head pending
    reg_read(8'h11, 8'h06);
    reg_write(8'h18, 8'h00);
    drain();
    reg_write(8'h18, 8'hF0);
    rate_case(2'h0, 2'h1, 2500, 88000);
    reg_write(8'h29, 8'h0B);
    rate_case(2'h1, 2'h2, 2000, 48000);
    reg_write(8'h39, 8'h90);
    rate_case(2'h2, 2'h3, 2000, 16000);
    reg_write(8'h10, 8'hF5);
    reg_read(8'h10, 8'h05);
    // Fast queue 3 code on the 10 Mbit port must fall back to unlimited
    reg_write(8'h28, 8'h0D);
    reg_write(8'h29, 8'hDB);
    rate_case(2'h1, 2'h3, 2000, 0);
    reg_write(8'h28, 8'h08);
    rate_case(2'h1, 2'h0, 1600, 8000);
    reg_write(8'h10, 8'h00);
    reg_write(8'h38, 8'hF0);
    rate_case(2'h2, 2'h1, 2500, 0);
    reg_write(8'h38, 8'h0A);
    rate_case(2'h2, 2'h2, 2000, 32000);
    wrap_up();
  end
endmodule
